// ---- bench/famsr_host.sv ----
module famsr_host
   import famsr_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic [7:0] rd_data,
   input  wire logic       rd_ack,
   input  wire logic       cmd_nak,
   output famsr_req_t      req
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [8:0] ans;
   logic       nak;

   initial req = '0;

   // one command pulse, answer taken while it stands, before the pulse drops
   task automatic xfer(input logic rd, input logic wr, input logic [7:0] cmd,
                       input logic [7:0] wd);
      @(negedge mclk);
      req = '{rd, wr, cmd, wd};
      @(negedge mclk);
      ans = {rd_ack, rd_data};
      nak = cmd_nak;
      req = '{1'b0, 1'b0, ~cmd, ~wd};
   endtask : xfer
endmodule : famsr_host

// ---- bench/testbench.sv ----
module testbench
   import famsr_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;

`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fails++; \
   $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end

   logic       mclk = 1'b0;
   logic       srst = 1'b1;
   famsr_req_t req;
   famsr_src_t warn_src = '0;
   famsr_src_t fault_src = '0;
   logic [3:0] phase_en = 4'h0;
   logic       power_save_input_n = 1'b1;
   logic       power_good = 1'b0;
   logic       ready = 1'b0;
   logic [7:0] rd_data;
   logic       rd_ack, cmd_nak, alert_out, fault_out;
   int         fails = 0;
   int         compares = 0;
   int         cycles = 0;
   int         mb[5] = '{0, 2, 3, 6, 7};

   always #50 mclk = ~mclk;

   famsr_regs uut (.mclk(mclk), .srst(srst), .req(req), .warn_src(warn_src),
      .fault_src(fault_src), .phase_en(phase_en), .power_good(power_good),
      .power_save_input_n(power_save_input_n), .ready(ready), .rd_data(rd_data),
      .rd_ack(rd_ack), .cmd_nak(cmd_nak), .alert_out(alert_out), .fault_out(fault_out));

   famsr_host host (.mclk(mclk), .rd_data(rd_data), .rd_ack(rd_ack),
      .cmd_nak(cmd_nak), .req(req));

   task automatic tally_and_finish;
      $display("compares=%0d fails=%0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : tally_and_finish

   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         fails++;
         tally_and_finish();
      end
   end

   task automatic rd(input logic [7:0] cmd, input logic [7:0] exp);
      host.xfer(1'b1, 1'b0, cmd, 8'h00);
      `CHK(host.ans, {1'b1, exp})
   endtask : rd

   task automatic wr(input logic [7:0] cmd, input logic [7:0] d, input logic nak);
      host.xfer(1'b0, 1'b1, cmd, d);
      `CHK(host.nak, nak)
   endtask : wr

   task automatic settle;
      repeat (2) @(negedge mclk);
   endtask : settle

   initial
   begin
      repeat (8) @(negedge mclk);
      srst = 1'b0;
      rd(FAMSR_CMD_ALERT_MASK, 8'h00);
      rd(FAMSR_CMD_FAULT_MASK, 8'h00);
      rd(FAMSR_CMD_GEN_STATUS, 8'h00);
      rd(FAMSR_CMD_PHASE_STATUS, 8'h00);
      wr(FAMSR_CMD_ALERT_MASK, 8'hff, 1'b0);
      rd(FAMSR_CMD_ALERT_MASK, 8'hcd);
      wr(FAMSR_CMD_GEN_STATUS, 8'hff, 1'b1);
      rd(FAMSR_CMD_GEN_STATUS, 8'h00);
      host.xfer(1'b1, 1'b0, 8'h00, 8'h00);
      `CHK({host.nak, host.ans}, 10'h200)
      ready = 1'b1;
      power_good = 1'b1;
      for (int i = 0; i < 5; i++)
      begin
         wr(FAMSR_CMD_ALERT_MASK, 8'h00, 1'b0);
         wr(FAMSR_CMD_FAULT_MASK, 8'h00, 1'b0);
         warn_src = famsr_src_t'(5'h01 << i);
         fault_src = famsr_src_t'(5'h01 << i);
         settle();
         `CHK({alert_out, fault_out}, 2'b11)
         rd(FAMSR_CMD_GEN_STATUS, 8'hf0);
         wr(FAMSR_CMD_ALERT_MASK, 8'h01 << mb[i], 1'b0);
         settle();
         `CHK({alert_out, fault_out}, 2'b01)
         wr(FAMSR_CMD_FAULT_MASK, 8'h01 << mb[i], 1'b0);
         wr(FAMSR_CMD_ALERT_MASK, 8'h00, 1'b0);
         settle();
         `CHK({alert_out, fault_out}, {i != 1, 1'b0})
         rd(FAMSR_CMD_GEN_STATUS, (i == 1) ? 8'h30 : 8'h70);
      end
      warn_src = '0;
      fault_src = '0;
      phase_en = 4'hf;
      power_save_input_n = 1'b0;
      repeat (6) @(negedge mclk);
      rd(FAMSR_CMD_PHASE_STATUS, 8'h3c);
      phase_en = 4'h5;
      power_save_input_n = 1'b1;
      repeat (6) @(negedge mclk);
      rd(FAMSR_CMD_PHASE_STATUS, 8'h10);
      phase_en = 4'ha;
      settle();
      rd(FAMSR_CMD_PHASE_STATUS, 8'h28);
      srst = 1'b1;
      @(negedge mclk);
      srst = 1'b0;
      rd(FAMSR_CMD_FAULT_MASK, 8'h00);
      tally_and_finish();
   end
endmodule : testbench

// ---- core/famsr_regs.sv ----
module famsr_regs
   import famsr_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       srst,
   input  wire famsr_req_t req,
   input  wire famsr_src_t warn_src,
   input  wire famsr_src_t fault_src,
   input  wire logic [3:0] phase_en,
   input  wire logic       power_save_input_n,
   input  wire logic       power_good,
   input  wire logic       ready,
   output logic [7:0]      rd_data,
   output logic            rd_ack,
   output logic            cmd_nak,
   output logic            alert_out,
   output logic            fault_out
);

   famsr_state_t st_r;
   famsr_state_t st_nxt;
   logic [7:0]   am_eff;
   logic [7:0]   fm_eff;

   always_comb
   begin
      st_nxt = st_r;
      am_eff = st_r.alert_mask;
      fm_eff = st_r.fault_mask;
      // either mask's bit 2 silences the input-voltage alert
      am_eff[FAMSR_MB_INVOLT] = st_r.alert_mask[FAMSR_MB_INVOLT]
                                | st_r.fault_mask[FAMSR_MB_INVOLT];   // [R2]

      st_nxt.alert = (warn_src.output_voltage           & ~am_eff[FAMSR_MB_OVOLT])  // [R9]
                   | (warn_src.output_current           & ~am_eff[FAMSR_MB_OCURR])  // [R9]
                   | (warn_src.comm_memory_logic_status & ~am_eff[FAMSR_MB_COMM])   // [R1]
                   | (warn_src.monitored_input_voltage  & ~am_eff[FAMSR_MB_INVOLT]) // [R2]
                   | (warn_src.output_power             & ~am_eff[FAMSR_MB_OPWR]);  // [R3]

      st_nxt.fault = (fault_src.output_voltage           & ~fm_eff[FAMSR_MB_OVOLT])  // [R4]
                   | (fault_src.output_current           & ~fm_eff[FAMSR_MB_OCURR])  // [R4]
                   | (fault_src.comm_memory_logic_status & ~fm_eff[FAMSR_MB_COMM])   // [R4]
                   | (fault_src.monitored_input_voltage  & ~fm_eff[FAMSR_MB_INVOLT])
                   | (fault_src.output_power             & ~fm_eff[FAMSR_MB_OPWR]);  // [R5]

      // power-save pin: three stages, level taken once last two agree
      st_nxt.psave_sync = {st_r.psave_sync[1:0], power_save_input_n};
      if (st_r.psave_sync[1] == st_r.psave_sync[2])
      begin
         st_nxt.psave_n_level = st_r.psave_sync[2];
      end

      st_nxt.gen_status = FAMSR_STATUS_RST;
      st_nxt.gen_status[FAMSR_GS_FAULT] = st_nxt.fault;   // [R10]
      st_nxt.gen_status[FAMSR_GS_ALERT] = st_nxt.alert;   // [R10]
      st_nxt.gen_status[FAMSR_GS_PGOOD] = power_good;     // [R6]
      st_nxt.gen_status[FAMSR_GS_READY] = ready;          // [R10]

      st_nxt.phase_status = FAMSR_STATUS_RST;
      st_nxt.phase_status[FAMSR_PS_PH4] = phase_en[3];    // [R7]
      st_nxt.phase_status[FAMSR_PS_PH3] = phase_en[2];    // [R7]
      st_nxt.phase_status[FAMSR_PS_PH2] = phase_en[1];    // [R7]
      st_nxt.phase_status[FAMSR_PS_PSAVE] = ~st_r.psave_n_level;  // [R8]

      // command port
      st_nxt.rd_ack  = 1'b0;
      st_nxt.cmd_nak = 1'b0;
      st_nxt.rd_data = 8'h00;
      if (req.wr)
      begin
         unique case (req.cmd)
            FAMSR_CMD_ALERT_MASK: st_nxt.alert_mask = req.wdata & FAMSR_MASK_WR_BITS;
            FAMSR_CMD_FAULT_MASK: st_nxt.fault_mask = req.wdata & FAMSR_MASK_WR_BITS;
            default:              st_nxt.cmd_nak    = 1'b1;
         endcase
      end
      if (req.rd)
      begin
         st_nxt.rd_ack = 1'b1;
         unique case (req.cmd)
            FAMSR_CMD_ALERT_MASK:   st_nxt.rd_data = st_r.alert_mask;
            FAMSR_CMD_FAULT_MASK:   st_nxt.rd_data = st_r.fault_mask;
            FAMSR_CMD_GEN_STATUS:   st_nxt.rd_data = st_r.gen_status;   // [R10]
            FAMSR_CMD_PHASE_STATUS: st_nxt.rd_data = st_r.phase_status;
            default:
            begin
               st_nxt.rd_ack  = 1'b0;
               st_nxt.cmd_nak = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         st_r              <= '0;
         st_r.alert_mask   <= FAMSR_ALERT_MASK_RST;
         st_r.fault_mask   <= FAMSR_FAULT_MASK_RST;
         st_r.gen_status   <= FAMSR_STATUS_RST;     // [R10]
         st_r.phase_status <= FAMSR_STATUS_RST;
         st_r.psave_sync    <= FAMSR_PSAVE_SYNC_RST;
         st_r.psave_n_level <= 1'b1;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign rd_data   = st_r.rd_data;
   assign rd_ack    = st_r.rd_ack;
   assign cmd_nak   = st_r.cmd_nak;
   assign alert_out = st_r.alert;
   assign fault_out = st_r.fault;

   // checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);

   property p_comm_alert;
      st_r.alert_mask[FAMSR_MB_COMM] && warn_src == famsr_src_t'(5'h04)
         && req.wr == 1'b0 |=> !alert_out;
   endproperty
   a_comm_alert: assert property (p_comm_alert) else $error("comm alert not masked"); // [R1]

   property p_involt_alert;
      (st_r.alert_mask[FAMSR_MB_INVOLT] || st_r.fault_mask[FAMSR_MB_INVOLT])
         && warn_src == famsr_src_t'(5'h02) && !req.wr |=> !alert_out;
   endproperty
   a_involt_alert: assert property (p_involt_alert) else $error("input alert not masked"); // [R2]

   property p_involt_by_fault;
      st_r.fault_mask[FAMSR_MB_INVOLT] && warn_src == famsr_src_t'(5'h02)
         |=> !alert_out;
   endproperty
   a_involt_by_fault: assert property (p_involt_by_fault) else $error("input alert leak"); // [R2]

   property p_opwr_alert;
      warn_src == famsr_src_t'(5'h01) && !req.wr
         |=> (alert_out == !$past(st_r.alert_mask[FAMSR_MB_OPWR]));
   endproperty
   a_opwr_alert: assert property (p_opwr_alert) else $error("power alert wrong"); // [R3]

   property p_fault_mask;
      fault_src == famsr_src_t'(5'h10) && !req.wr
         |=> (fault_out == !$past(st_r.fault_mask[FAMSR_MB_OVOLT]));
   endproperty
   a_fault_mask: assert property (p_fault_mask) else $error("voltage fault mask wrong"); // [R4]

   property p_comm_fault;
      st_r.fault_mask[FAMSR_MB_COMM] && fault_src == famsr_src_t'(5'h04)
         |=> !fault_out;
   endproperty
   a_comm_fault: assert property (p_comm_fault) else $error("comm fault not masked"); // [R4]

   property p_ocurr_fault;
      st_r.fault_mask[FAMSR_MB_OCURR] && fault_src == famsr_src_t'(5'h08)
         |=> !fault_out;
   endproperty
   a_ocurr_fault: assert property (p_ocurr_fault) else $error("current fault not masked"); // [R4]

   property p_fault_unmasked;
      fault_src != '0 && st_r.fault_mask == 8'h00 |=> fault_out;
   endproperty
   a_fault_unmasked: assert property (p_fault_unmasked) else $error("fault not raised"); // [R4]

   property p_opwr_fault;
      st_r.fault_mask[FAMSR_MB_OPWR] && fault_src == famsr_src_t'(5'h01)
         && !req.wr |=> !fault_out;
   endproperty
   a_opwr_fault: assert property (p_opwr_fault) else $error("power fault not masked"); // [R5]

   property p_pgood;
      power_good |=> st_r.gen_status[FAMSR_GS_PGOOD];
   endproperty
   a_pgood: assert property (p_pgood) else $error("legacy power good lost"); // [R6]

   property p_pgood_low;
      !power_good |=> !st_r.gen_status[FAMSR_GS_PGOOD];
   endproperty
   a_pgood_low: assert property (p_pgood_low) else $error("legacy power good stuck"); // [R6]

   property p_phase;
      $stable(phase_en) |=> st_r.phase_status[5:3] == $past(phase_en[3:1]);
   endproperty
   a_phase: assert property (p_phase) else $error("phase status wrong"); // [R7]

   property p_phase_reserved;
      st_r.phase_status[7:6] == 2'h0 && st_r.phase_status[1:0] == 2'h0;
   endproperty
   a_phase_reserved: assert property (p_phase_reserved) else $error("phase spare set"); // [R7]

   property p_phase_read;
      req.rd && req.cmd == FAMSR_CMD_PHASE_STATUS
         |=> rd_ack && rd_data == $past(st_r.phase_status);
   endproperty
   a_phase_read: assert property (p_phase_read) else $error("phase read wrong"); // [R7]

   property p_psave;
      !power_save_input_n [*6] |-> ##[0:2] st_r.phase_status[FAMSR_PS_PSAVE];
   endproperty
   a_psave: assert property (p_psave) else $error("power save not reported"); // [R8]

   property p_psave_clear;
      power_save_input_n [*6] |-> ##[0:2] !st_r.phase_status[FAMSR_PS_PSAVE];
   endproperty
   a_psave_clear: assert property (p_psave_clear) else $error("power save stuck"); // [R8]

   property p_ocurr_alert;
      st_r.alert_mask[FAMSR_MB_OCURR] && warn_src == famsr_src_t'(5'h08)
         && !req.wr |=> !alert_out;
   endproperty
   a_ocurr_alert: assert property (p_ocurr_alert) else $error("current alert not masked"); // [R9]

   property p_ovolt_alert;
      st_r.alert_mask[FAMSR_MB_OVOLT] && warn_src == famsr_src_t'(5'h10)
         |=> !alert_out;
   endproperty
   a_ovolt_alert: assert property (p_ovolt_alert) else $error("voltage alert not masked"); // [R9]

   property p_alert_unmasked;
      warn_src != '0 && st_r.alert_mask == 8'h00 && st_r.fault_mask == 8'h00
         |=> alert_out;
   endproperty
   a_alert_unmasked: assert property (p_alert_unmasked) else $error("alert not raised"); // [R9]

   property p_mask_reserved;
      (st_r.alert_mask & ~FAMSR_MASK_WR_BITS) == 8'h00
         && (st_r.fault_mask & ~FAMSR_MASK_WR_BITS) == 8'h00;
   endproperty
   a_mask_reserved: assert property (p_mask_reserved) else $error("mask spare set"); // [R9]

   property p_alert_mask_write;
      req.wr && req.cmd == FAMSR_CMD_ALERT_MASK
         |=> st_r.alert_mask == ($past(req.wdata) & FAMSR_MASK_WR_BITS);
   endproperty
   a_alert_mask_write: assert property (p_alert_mask_write) else $error("alert mask write"); // [R9]

   property p_alert_mask_read;
      req.rd && req.cmd == FAMSR_CMD_ALERT_MASK
         |=> rd_ack && rd_data == $past(st_r.alert_mask);
   endproperty
   a_alert_mask_read: assert property (p_alert_mask_read) else $error("alert mask read"); // [R9]

   property p_fault_mask_write;
      req.wr && req.cmd == FAMSR_CMD_FAULT_MASK
         |=> st_r.fault_mask == ($past(req.wdata) & FAMSR_MASK_WR_BITS);
   endproperty
   a_fault_mask_write: assert property (p_fault_mask_write) else $error("fault mask write"); // [R4]

   property p_fault_mask_read;
      req.rd && req.cmd == FAMSR_CMD_FAULT_MASK
         |=> rd_ack && rd_data == $past(st_r.fault_mask);
   endproperty
   a_fault_mask_read: assert property (p_fault_mask_read) else $error("fault mask read"); // [R4]

   property p_alert_idle;
      warn_src == '0 |=> !alert_out;
   endproperty
   a_alert_idle: assert property (p_alert_idle) else $error("alert without source"); // [R10]

   property p_fault_idle;
      fault_src == '0 |=> !fault_out;
   endproperty
   a_fault_idle: assert property (p_fault_idle) else $error("fault without source"); // [R10]

   property p_ready;
      1'b1 |=> st_r.gen_status[FAMSR_GS_READY] == $past(ready);
   endproperty
   a_ready: assert property (p_ready) else $error("ready bit wrong"); // [R10]

   property p_gen_reserved;
      st_r.gen_status[3:0] == 4'h0;
   endproperty
   a_gen_reserved: assert property (p_gen_reserved) else $error("status spare set"); // [R10]

   property p_rd_idle;
      !req.rd |=> !rd_ack && rd_data == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read answer without request"); // [R10]

   property p_ro_write;
      req.wr && req.cmd != FAMSR_CMD_ALERT_MASK && req.cmd != FAMSR_CMD_FAULT_MASK
         |=> cmd_nak && st_r.alert_mask == $past(st_r.alert_mask)
             && st_r.fault_mask == $past(st_r.fault_mask);
   endproperty
   a_ro_write: assert property (p_ro_write) else $error("refused write changed state"); // [R10]

   property p_bad_read;
      req.rd && (req.cmd < FAMSR_CMD_ALERT_MASK || req.cmd > FAMSR_CMD_PHASE_STATUS)
         |=> cmd_nak && !rd_ack;
   endproperty
   a_bad_read: assert property (p_bad_read) else $error("bad read not refused"); // [R10]

   property p_gen_read;
      req.rd && req.cmd == FAMSR_CMD_GEN_STATUS
         |=> rd_ack && rd_data[FAMSR_GS_FAULT] == $past(fault_out)
             && rd_data[FAMSR_GS_ALERT] == $past(alert_out);
   endproperty
   a_gen_read: assert property (p_gen_read) else $error("general status read wrong"); // [R10]

   c_alert: cover property (alert_out ##1 !alert_out);
   c_fault: cover property (fault_out && st_r.fault_mask != 8'h00);
   c_psave: cover property (st_r.phase_status[FAMSR_PS_PSAVE] ##1 !st_r.phase_status[FAMSR_PS_PSAVE]);
   c_nak:   cover property (cmd_nak);

endmodule : famsr_regs

// ---- pkg/famsr_pkg.sv ----
// Operation
// (R1) alert mask bit 3 blocks alerts from comm/memory/logic status.
// (R2) alert or fault mask bit 2 blocks the monitored-input-voltage alert.
// (R3) alert mask bit 0 blocks the output-power-limit alert.
// (R4) fault mask bits 7,6,3 block output-voltage, output-current, comm faults.
// (R5) fault mask bit 0 blocks the output-power-limit fault.
// (R6) general status bit 5 power-good is legacy; host uses status word bit 3.
// (R7) phase status bits 5,4,3 follow enables of phases 4,3,2.
// (R8) phase status bit 2 is set while power-save input (active low) is asserted.
// (R9) alert mask bits 7,6 block output-voltage and output-current alerts.
// (R10) general status: bit 7 fault, bit 6 alert, bit 4 ready; reads zero at reset.
package famsr_pkg;

   localparam logic [7:0] FAMSR_CMD_ALERT_MASK   = 8'hf9;
   localparam logic [7:0] FAMSR_CMD_FAULT_MASK   = 8'hfa;
   localparam logic [7:0] FAMSR_CMD_GEN_STATUS   = 8'hfb;
   localparam logic [7:0] FAMSR_CMD_PHASE_STATUS = 8'hfc;

   localparam logic [7:0] FAMSR_ALERT_MASK_RST   = 8'h00;
   localparam logic [7:0] FAMSR_FAULT_MASK_RST   = 8'h00;
   localparam logic [7:0] FAMSR_STATUS_RST       = 8'h00;
   // writable bits of both mask registers
   localparam logic [7:0] FAMSR_MASK_WR_BITS     = 8'hcd;

   // mask bit positions
   localparam int FAMSR_MB_OVOLT  = 7;
   localparam int FAMSR_MB_OCURR  = 6;
   localparam int FAMSR_MB_COMM   = 3;
   localparam int FAMSR_MB_INVOLT = 2;
   localparam int FAMSR_MB_OPWR   = 0;

   // general status bit positions
   localparam int FAMSR_GS_FAULT = 7;
   localparam int FAMSR_GS_ALERT = 6;
   localparam int FAMSR_GS_PGOOD = 5;
   localparam int FAMSR_GS_READY = 4;

   // phase status bit positions
   localparam int FAMSR_PS_PH4 = 5;
   localparam int FAMSR_PS_PH3 = 4;
   localparam int FAMSR_PS_PH2 = 3;
   localparam int FAMSR_PS_PSAVE = 2;

   localparam logic [2:0] FAMSR_PSAVE_SYNC_RST = 3'h7;

   // one flag per status source class
   typedef struct packed {
      logic output_voltage;
      logic output_current;
      logic comm_memory_logic_status;
      logic monitored_input_voltage;
      logic output_power;
   } famsr_src_t;

   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [7:0] cmd;
      logic [7:0] wdata;
   } famsr_req_t;

   typedef struct packed {
      logic [7:0] alert_mask;
      logic [7:0] fault_mask;
      logic [7:0] gen_status;
      logic [7:0] phase_status;
      logic [2:0] psave_sync;
      logic       psave_n_level;
      logic       alert;
      logic       fault;
      logic [7:0] rd_data;
      logic       rd_ack;
      logic       cmd_nak;
   } famsr_state_t;

endpackage : famsr_pkg
